// >>> logic/lmc_regs.sv
// maintenance control register bank with error insert and counter
module lmc_regs
    import lmc_pkg::*;
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // control interface
    input  wire lmc_req_t    req,
    output logic [7:0]       reg_rdata,
    // transmit path
    input  wire logic        tx_bit_en,
    input  wire logic        tx_data_in,
    output logic             tx_data_out,
    output logic             violation_insert,
    output logic             prbs_error_insert,
    // receive side setup and events
    input  wire lmc_err_t    err_evt,
    input  wire logic        one_second_tick,
    output logic [7:0]       rx_activate_pattern,
    output logic [7:0]       rx_deactivate_pattern,
    output logic             excess_zero_def_sel,
    output logic             counter_report_mode,
    output logic [7:0]       alarm_mask,
    // counter results
    output logic [7:0]       count_result_low,
    output logic [7:0]       count_result_high
);
    logic [7:0]  tx_code_r, rx_act_r, rx_deact_r, err_ctrl_r;
    logic [7:0]  alm_mask_r, code_len_r, tx_pattern_sel_ctrl_r, rdata_r;
    logic [7:0]  rx_act_out_r, rx_deact_out_r, cnt_lo_r, cnt_hi_r;
    logic [15:0] err_cnt_r, err_cnt_nxt;
    logic        tx_out_r, viol_r, prbs_ins_r;
    logic        code_bit;

    // decode
    wire wr_code  = req.wr && req.addr == LMC_OFS_TX_CODE;
    wire wr_act   = req.wr && req.addr == LMC_OFS_RX_ACT;
    wire wr_deact = req.wr && req.addr == LMC_OFS_RX_DEACT;
    wire wr_ctrl  = req.wr && req.addr == LMC_OFS_ERR_CTRL;
    wire wr_mask  = req.wr && req.addr == LMC_OFS_ALM_MASK;
    wire wr_len   = req.wr && req.addr == LMC_OFS_CODE_LEN;
    wire wr_tx_pattern_sel  = req.wr && req.addr == LMC_OFS_TX_PATTERN_SEL_CTRL;

    // single-shot actions fire only on a written 0 to 1 change
    wire viol_rise = wr_ctrl && req.wdata[LMC_BIT_VIOL_INS]
                     && !err_ctrl_r[LMC_BIT_VIOL_INS]; // [RQ5]
    wire prbs_rise = wr_ctrl && req.wdata[LMC_BIT_PRBS_INS]
                     && !err_ctrl_r[LMC_BIT_PRBS_INS]; // [RQ6]
    wire trf_rise  = wr_ctrl && req.wdata[LMC_BIT_COUNTER_TRANSFER]
                     && !err_ctrl_r[LMC_BIT_COUNTER_TRANSFER]; // [RQ10]
    wire auto_mode = err_ctrl_r[LMC_BIT_CNT_MODE]; // [RQ9]
    wire transfer  = trf_rise || (auto_mode && one_second_tick); // [RQ9]

    wire [1:0] err_sel   = err_ctrl_r[LMC_POS_ERR_SEL +: 2];
    wire [1:0] tx_len    = code_len_r[LMC_POS_TX_LEN +: 2];
    wire [1:0] act_len   = code_len_r[LMC_POS_ACT_LEN +: 2];
    wire [1:0] deact_len = code_len_r[LMC_POS_DEACT_LEN +: 2];
    wire       loop_sel  = tx_pattern_sel_ctrl_r[LMC_POS_TX_PATTERN_SEL +: 2]
                           == LMC_TX_PATTERN_SEL_LOOP_CODE; // [RQ14]
    wire [7:0] act_mask   = 8'hFF >> (2'd3 - act_len); // [RQ4]
    wire [7:0] deact_mask = 8'hFF >> (2'd3 - deact_len); // [RQ4]

    // error selection; both types at once add two
    wire [1:0] inc =
        (err_sel == LMC_ERR_PRBS) ? {1'b0, err_evt.prbs} :
        (err_sel == LMC_ERR_EXZ)  ? {1'b0, err_evt.exz}  :
        (err_sel == LMC_ERR_CV)   ? {1'b0, err_evt.cv}   :
        {1'b0, err_evt.cv} + {1'b0, err_evt.exz}; // [RQ8]
    wire [16:0] cnt_sum  = {1'b0, err_cnt_r} + {15'h0000, inc};
    // saturate rather than wrap so a stale count is never small
    wire [15:0] cnt_sat  = cnt_sum[16] ? LMC_CNT_MAX : cnt_sum[15:0];
    // an event in the transfer cycle starts the new count
    assign err_cnt_nxt = transfer ? {14'h0000, inc} : cnt_sat; // [RQ10]

    wire [7:0] rd_mux =
        (req.addr == LMC_OFS_TX_CODE)   ? tx_code_r   :
        (req.addr == LMC_OFS_RX_ACT)    ? rx_act_r    :
        (req.addr == LMC_OFS_RX_DEACT)  ? rx_deact_r  :
        (req.addr == LMC_OFS_ERR_CTRL)  ? err_ctrl_r  :
        (req.addr == LMC_OFS_ALM_MASK)  ? alm_mask_r  :
        (req.addr == LMC_OFS_CODE_LEN)  ? code_len_r  :
        (req.addr == LMC_OFS_TX_PATTERN_SEL_CTRL) ? tx_pattern_sel_ctrl_r :
        (req.addr == LMC_OFS_CNT_LOW)   ? cnt_lo_r    :
        (req.addr == LMC_OFS_CNT_HIGH)  ? cnt_hi_r    : 8'h00;

    lmc_code_gen u_code_gen (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .code     (tx_code_r),
        .len      (tx_len),
        .bit_en   (tx_bit_en),
        .restart  (!loop_sel),
        .code_bit (code_bit)
    );

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_code_r   <= LMC_RST_TX_CODE; // [RQ1]
            rx_act_r    <= LMC_RST_RX_ACT; // [RQ2]
            rx_deact_r  <= LMC_RST_RX_DEACT; // [RQ3]
            err_ctrl_r  <= LMC_RST_ERR_CTRL;
            alm_mask_r  <= LMC_RST_ALM_MASK; // [RQ11]
            code_len_r  <= LMC_RST_CODE_LEN; // [RQ13]
            tx_pattern_sel_ctrl_r <= LMC_RST_TX_PATTERN_SEL_CTRL;
        end
        else
        begin
            if (wr_code)  tx_code_r   <= req.wdata; // [RQ1]
            if (wr_act)   rx_act_r    <= req.wdata; // [RQ2]
            if (wr_deact) rx_deact_r  <= req.wdata; // [RQ3]
            if (wr_ctrl)  err_ctrl_r  <= req.wdata & 8'h7F;
            if (wr_mask)  alm_mask_r  <= req.wdata; // [RQ11] [RQ12]
            if (wr_len)   code_len_r  <= req.wdata & 8'h3F; // [RQ13]
            if (wr_tx_pattern_sel)  tx_pattern_sel_ctrl_r <= req.wdata & 8'h60;
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            err_cnt_r <= 16'h0000;
            cnt_lo_r  <= 8'h00;
            cnt_hi_r  <= 8'h00;
        end
        else
        begin
            err_cnt_r <= err_cnt_nxt; // [RQ8]
            if (transfer)
            begin
                cnt_lo_r <= err_cnt_r[7:0]; // [RQ10]
                cnt_hi_r <= err_cnt_r[15:8]; // [RQ10]
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_out_r       <= 1'b0;
            viol_r         <= 1'b0;
            prbs_ins_r     <= 1'b0;
            rdata_r        <= 8'h00;
            rx_act_out_r   <= 8'h00;
            rx_deact_out_r <= 8'h00;
        end
        else
        begin
            tx_out_r       <= loop_sel ? code_bit : tx_data_in; // [RQ14]
            viol_r         <= viol_rise; // [RQ5]
            prbs_ins_r     <= prbs_rise; // [RQ6]
            rx_act_out_r   <= rx_act_r & act_mask; // [RQ4]
            rx_deact_out_r <= rx_deact_r & deact_mask; // [RQ4]
            if (req.rd)
                rdata_r <= rd_mux;
        end
    end

    assign tx_data_out           = tx_out_r;
    assign violation_insert      = viol_r;
    assign prbs_error_insert     = prbs_ins_r;
    assign rx_activate_pattern   = rx_act_out_r;
    assign rx_deactivate_pattern = rx_deact_out_r;
    assign excess_zero_def_sel   = err_ctrl_r[LMC_BIT_EXCESS_ZERO_DEF_SEL]; // [RQ7]
    assign counter_report_mode   = err_ctrl_r[LMC_BIT_CNT_MODE]; // [RQ9]
    assign alarm_mask            = alm_mask_r; // [RQ11] [RQ12]
    assign count_result_low      = cnt_lo_r;
    assign count_result_high     = cnt_hi_r;
    assign reg_rdata             = rdata_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    chk_viol_single: assert property ( // [RQ5]
        violation_insert |=> !violation_insert)
        else $error("violation insert lasted more than one cycle");
    chk_viol_cause: assert property ( // [RQ5]
        violation_insert |-> $past(wr_ctrl)
        && $past(req.wdata[LMC_BIT_VIOL_INS])
        && !$past(err_ctrl_r[LMC_BIT_VIOL_INS]))
        else $error("violation insert without a rising write");
    chk_prbs_once: assert property ( // [RQ6]
        prbs_rise |=> prbs_error_insert ##1 !prbs_error_insert)
        else $error("prbs error insert not a single pulse");
    chk_transfer_copy: assert property ( // [RQ10]
        trf_rise |=> {count_result_high, count_result_low}
        == $past(err_cnt_r) && err_cnt_r == {14'h0000, $past(inc)})
        else $error("transfer did not copy and clear the count");
    chk_manual_hold: assert property ( // [RQ9]
        !auto_mode && !trf_rise |=> $stable(count_result_low))
        else $error("result changed without transfer in manual mode");
    chk_cnt_sel_prbs: assert property ( // [RQ8]
        err_sel == LMC_ERR_PRBS && !transfer && !err_evt.prbs
        |=> $stable(err_cnt_r))
        else $error("counter moved without a selected error");
    chk_mask_reset: assert property ( // [RQ11]
        $rose(rst_n) |-> alarm_mask == 8'hFF)
        else $error("alarm mask not all ones after reset");
    chk_loop_out: assert property ( // [RQ14]
        loop_sel |=> tx_data_out == $past(code_bit))
        else $error("loop code not on transmit output");
    chk_act_len: assert property ( // [RQ4]
        $stable(rx_act_r) && $stable(act_len) |=>
        (rx_activate_pattern & ~$past(act_mask)) == 8'h00)
        else $error("activate pattern has bits above length");
    chk_deact_len: assert property ( // [RQ4]
        $stable(rx_deact_r) && $stable(deact_len) |=>
        (rx_deactivate_pattern & ~$past(deact_mask)) == 8'h00)
        else $error("deactivate pattern has bits above length");
    chk_trf_refused: assert property ( // [RQ10]
        wr_ctrl && req.wdata[LMC_BIT_COUNTER_TRANSFER]
        && err_ctrl_r[LMC_BIT_COUNTER_TRANSFER] && !auto_mode
        |=> $stable(count_result_high) && $stable(count_result_low))
        else $error("transfer taken from a rewrite of a set bit");
    chk_pass_through: assert property ( // [RQ14]
        !loop_sel |=> tx_data_out == $past(tx_data_in))
        else $error("transmit data not passed through");
    chk_rdata_hold: assert property (
        !req.rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
endmodule : lmc_regs

// >>> include/lmc_pkg.sv
// constants and carrier types for the line maintenance control registers
// Functional notes
// RQ1 - tx loop code register, reset 00001
// RQ2 - rx activate pattern register, reset 00001
// RQ3 - rx deactivate pattern register, reset 001001
// RQ4 - code length uses only low bits
// RQ5 - bit 6 rise inserts one violation
// RQ6 - bit 5 rise corrupts one prbs bit
// RQ7 - bit 4 selects ansi or fcc zeros
// RQ8 - error type field selects counted errors
// RQ9 - bit 1 selects manual or auto report
// RQ10 - bit 0 rise transfers count, clears counter
// RQ11 - mask bits: 1 masks, reset all ones
// RQ12 - mask bit order eq down to los
// RQ13 - two-bit length fields, 5 to 8 bits
// RQ14 - pattern select 11 sends loop code
package lmc_pkg;
    // register offsets
    localparam logic [7:0] LMC_OFS_TX_PATTERN_SEL_CTRL = 8'h0D;
    localparam logic [7:0] LMC_OFS_CODE_LEN  = 8'h0F;
    localparam logic [7:0] LMC_OFS_TX_CODE   = 8'h10;
    localparam logic [7:0] LMC_OFS_RX_ACT    = 8'h11;
    localparam logic [7:0] LMC_OFS_RX_DEACT  = 8'h12;
    localparam logic [7:0] LMC_OFS_ERR_CTRL  = 8'h13;
    localparam logic [7:0] LMC_OFS_ALM_MASK  = 8'h14;
    localparam logic [7:0] LMC_OFS_CNT_LOW   = 8'h20;
    localparam logic [7:0] LMC_OFS_CNT_HIGH  = 8'h21;
    // reset values
    localparam logic [7:0] LMC_RST_TX_CODE   = 8'h01;
    localparam logic [7:0] LMC_RST_RX_ACT    = 8'h01;
    localparam logic [7:0] LMC_RST_RX_DEACT  = 8'h09;
    localparam logic [7:0] LMC_RST_ERR_CTRL  = 8'h00;
    localparam logic [7:0] LMC_RST_ALM_MASK  = 8'hFF;
    localparam logic [7:0] LMC_RST_CODE_LEN  = 8'h01;
    localparam logic [7:0] LMC_RST_TX_PATTERN_SEL_CTRL = 8'h00;
    // error control fields
    localparam int LMC_BIT_VIOL_INS  = 6;
    localparam int LMC_BIT_PRBS_INS  = 5;
    localparam int LMC_BIT_EXCESS_ZERO_DEF_SEL   = 4;
    localparam int LMC_POS_ERR_SEL   = 2;
    localparam int LMC_BIT_CNT_MODE  = 1;
    localparam int LMC_BIT_COUNTER_TRANSFER   = 0;
    // length fields and pattern select field
    localparam int LMC_POS_TX_LEN    = 4;
    localparam int LMC_POS_ACT_LEN   = 2;
    localparam int LMC_POS_DEACT_LEN = 0;
    localparam int LMC_POS_TX_PATTERN_SEL      = 5;
    localparam logic [1:0] LMC_TX_PATTERN_SEL_LOOP_CODE = 2'b11;
    // error type selections
    localparam logic [1:0] LMC_ERR_PRBS   = 2'b00;
    localparam logic [1:0] LMC_ERR_EXZ    = 2'b01;
    localparam logic [1:0] LMC_ERR_CV     = 2'b10;
    localparam logic [1:0] LMC_ERR_CV_EXZ = 2'b11;
    // shortest code is five bits, length code 00
    localparam logic [2:0] LMC_MIN_TOP    = 3'd4;
    localparam logic [15:0] LMC_CNT_MAX   = 16'hFFFF;

    typedef struct packed {
        logic prbs;
        logic exz;
        logic cv;
    } lmc_err_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } lmc_req_t;
endpackage : lmc_pkg

// >>> logic/lmc_code_gen.sv
// serialiser that repeats the low bits of a loop code
module lmc_code_gen
    import lmc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       rst_n,
    // code and control
    input  wire logic [7:0] code,
    input  wire logic [1:0] len,
    input  wire logic       bit_en,
    input  wire logic       restart,
    // serial code bit
    output logic            code_bit
);
    logic [2:0] idx_r;
    logic [2:0] idx_nxt;
    wire  [2:0] top_idx = {1'b0, len} + LMC_MIN_TOP;

    // msb of the selected length goes first; upper bits never reached
    assign code_bit = code[idx_r]; // [RQ4]
    assign idx_nxt  = (restart || idx_r == 3'd0 || idx_r > top_idx)
                    ? top_idx : idx_r - 3'd1;

    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            idx_r <= LMC_MIN_TOP;
        // a shortened length pulls the index back at once, not at next bit
        else if (bit_en || restart || idx_r > top_idx)
            idx_r <= idx_nxt; // [RQ4] [RQ13]
    end

    chk_idx_in_len: assert property ( // [RQ4]
        @(posedge mclk) disable iff (!rst_n)
        idx_r <= top_idx || $changed(len))
        else $error("code index beyond selected length");
endmodule : lmc_code_gen

// >>> bench/lmc_host.sv
// host model issuing register writes and reads to the bank
module lmc_host
    import lmc_pkg::*;
(
    // clock
    input  wire logic       mclk,
    // register requests and read answer
    output lmc_req_t        req,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    initial req = '0;
    // released fields show inverted values so stale data cannot pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge mclk);
        req <= '{~a, ~d, 1'b0, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        req <= '{a, 8'hff, 1'b0, 1'b1};
        @(posedge mclk);
        req <= '{~a, 8'h00, 1'b0, 1'b0};
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd
endmodule : lmc_host

// >>> bench/lmc_regs_tb.sv
// self-checking bench for the maintenance control register bank
module lmc_regs_tb
    import lmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic       mclk = 1'b0;
    logic       rst_n = 1'b0;
    lmc_req_t   req;
    lmc_err_t   err_evt = '0;
    logic       tx_bit_en = 1'b0;
    logic       tx_data_in = 1'b0;
    logic       one_second_tick = 1'b0;
    logic [7:0] reg_rdata, rx_activate_pattern, rx_deactivate_pattern;
    logic [7:0] alarm_mask, count_result_low, count_result_high, v;
    logic       tx_data_out, violation_insert, prbs_error_insert;
    logic       excess_zero_def_sel, counter_report_mode;
    int         n_fail = 0;
    int         checks = 0;
    int         n_viol = 0;
    int         n_perr = 0;
    wire [15:0] cnt_res = {count_result_high, count_result_low};

    lmc_regs i_dut (.mclk, .rst_n, .req, .reg_rdata, .tx_bit_en,
        .tx_data_in, .tx_data_out, .violation_insert, .prbs_error_insert,
        .err_evt, .one_second_tick, .rx_activate_pattern,
        .rx_deactivate_pattern, .excess_zero_def_sel, .counter_report_mode,
        .alarm_mask, .count_result_low, .count_result_high);
    lmc_host i_host (.mclk, .req, .reg_rdata);

    always #50 mclk = ~mclk;
    always @(posedge mclk)
    begin
        n_viol += int'(violation_insert);
        n_perr += int'(prbs_error_insert);
    end

    task automatic chk(input string nm, input logic [15:0] e, g);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic ev(input lmc_err_t e, input int n);
        repeat (n) @(posedge mclk) err_evt <= e;
        @(posedge mclk) err_evt <= '0;
    endtask : ev

    task automatic t_reset;
        logic [7:0] ofs [5] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14};
        logic [7:0] e [5] = '{8'h01, 8'h01, 8'h09, 8'h00, 8'hff};
        for (int i = 0; i < 5; i++)
        begin
            i_host.rd(ofs[i], v);
            chk("reset", 16'(e[i]), 16'(v));
        end
        chk("mask out", 16'h00ff, {8'h00, alarm_mask});
        chk("act out", 16'h0001, 16'(rx_activate_pattern));
        chk("deact out", 16'h0009, {8'h00, rx_deactivate_pattern});
    endtask : t_reset

    task automatic t_rw;
        i_host.wr(LMC_OFS_ALM_MASK, 8'h5a);
        i_host.rd(LMC_OFS_ALM_MASK, v);
        chk("mask reg", 16'h005a, {v, 8'h00} >> 8);
        chk("mask out", 16'h005a, {8'h00, alarm_mask});
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h92);
        i_host.rd(LMC_OFS_ERR_CTRL, v);
        chk("ctrl reg", 16'h0012, {8'h00, v});
        chk("excess_zero_def_sel", 16'h0001, 16'(excess_zero_def_sel));
        chk("report mode", 16'h0001, 16'(counter_report_mode));
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h00);
        @(negedge mclk);
        chk("excess_zero_def_sel", 16'h0000, 16'(excess_zero_def_sel));
        chk("report mode", 16'h0000, 16'(counter_report_mode));
        i_host.wr(8'h30, 8'h55);
        i_host.rd(8'h30, v);
        chk("unmapped", 16'h0000, {8'h00, v});
    endtask : t_rw

    task automatic t_len;
        i_host.wr(LMC_OFS_RX_ACT, 8'hff);
        i_host.wr(LMC_OFS_RX_DEACT, 8'hff);
        for (int i = 0; i < 4; i++)
        begin
            i_host.wr(LMC_OFS_CODE_LEN, {4'h0, i[1:0], i[1:0]});
            repeat (2) @(negedge mclk);
            v = 8'hff >> (3 - i);
            chk("act len", 16'(v), 16'(rx_activate_pattern));
            chk("deact", 16'(v), 16'(rx_deactivate_pattern));
        end
        i_host.wr(LMC_OFS_CODE_LEN, 8'h01);
    endtask : t_len

    task automatic t_ins;
        int v0 = n_viol;
        int p0 = n_perr;
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h40);
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h40);
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h00);
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h60);
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h00);
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h20);
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h00);
        repeat (3) @(negedge mclk);
        chk("violations", 16'd2, 16'(n_viol - v0));
        chk("prbs errors", 16'd2, 16'(n_perr - p0));
    endtask : t_ins

    task automatic t_cnt;
        logic [15:0] e [4] = '{16'd1, 16'd2, 16'd4, 16'd6};
        logic [1:0]  s;
        for (int i = 0; i < 4; i++)
        begin
            s = i[1:0];
            i_host.wr(LMC_OFS_ERR_CTRL, {4'h0, s, 2'b01});
            i_host.wr(LMC_OFS_ERR_CTRL, {4'h0, s, 2'b00});
            ev(3'b100, 1);
            ev(3'b010, 2);
            ev(3'b001, 4);
            chk("held", i == 0 ? 16'd0 : e[i - 1], cnt_res);
            i_host.wr(LMC_OFS_ERR_CTRL, {4'h0, s, 2'b01});
            @(negedge mclk);
            chk("count", e[i], cnt_res);
            i_host.rd(LMC_OFS_CNT_LOW, v);
            chk("count reg", e[i], {8'h00, v});
        end
        // counter was restarted by the last transfer, so auto mode sees 300
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h00);
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h02);
        ev(3'b100, 300);
        @(posedge mclk) one_second_tick <= 1'b1;
        @(posedge mclk) one_second_tick <= 1'b0;
        @(negedge mclk);
        chk("auto count", 16'd300, cnt_res);
        i_host.rd(LMC_OFS_CNT_HIGH, v);
        chk("count high", 16'h0001, 16'(v));
        i_host.wr(LMC_OFS_ERR_CTRL, 8'h00);
    endtask : t_cnt

    task automatic t_loop;
        logic [7:0] c = 8'hf6;
        @(posedge mclk) tx_data_in <= 1'b1;
        repeat (2) @(negedge mclk);
        chk("pass", 16'h0001, {15'h0, tx_data_out});
        i_host.wr(LMC_OFS_TX_CODE, c);
        i_host.wr(LMC_OFS_TX_PATTERN_SEL_CTRL, 8'h60);
        for (int k = 0; k < 10; k++)
        begin
            repeat (2) @(negedge mclk);
            chk("loop", 16'(c[4 - k % 5]), 16'(tx_data_out));
            @(posedge mclk) tx_bit_en <= 1'b1;
            @(posedge mclk) tx_bit_en <= 1'b0;
        end
        i_host.wr(LMC_OFS_TX_PATTERN_SEL_CTRL, 8'h00);
    endtask : t_loop

    task automatic results;
        if (n_fail == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    initial
    begin
        repeat (6) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_rw();
        t_len();
        t_ins();
        t_cnt();
        t_loop();
        results();
    end
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_fail++;
        results();
    end
endmodule : lmc_regs_tb
